// ===== src/spk_pkg.sv
// Purpose: constants and types shared by the stream segment packer
// Assumes: seven-byte transfer unit, one unit per bus cycle
// Notes:   control byte = {message end, next control byte position, length}
package spk_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 50;
    localparam int unsigned BUS_CYCLE_US    = 100;
    localparam int unsigned BUS_TICK_CYC    = (BUS_CYCLE_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned BUS_CNT_W       = 11;

    localparam int unsigned UNIT_BYTES      = 7;
    localparam int unsigned POS_W           = 3;
    localparam int unsigned SEG_LEN_W       = 6;
    localparam int unsigned SEG_MAX_LONG    = 63;
    localparam int unsigned SEG_BUF_DEPTH   = 63;

    localparam int unsigned CB_NEXT_POS_BIT = 6;
    localparam int unsigned CB_END_BIT      = 7;
    localparam logic [7:0]  IDLE_CB         = 8'h00;

    localparam int unsigned MODE_PACK_BIT   = 0;
    localparam int unsigned MODE_LONG_BIT   = 1;
    localparam logic [7:0]  MODE_RESET      = 8'h00;

    localparam logic [7:0]  SEQ_RESET       = 8'h00;

    localparam int unsigned FIFO_WIDTH      = 9;
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned FIFO_AW         = 4;

    typedef enum logic [4:0] {
        ST_WAIT   = 5'b00001,
        ST_GATHER = 5'b00010,
        ST_CTRL   = 5'b00100,
        ST_DATA   = 5'b01000,
        ST_SEND   = 5'b10000
    } spk_state_e;
endpackage : spk_pkg

// ===== src/spk_fifo.sv
// Purpose: byte buffer between the message source and the packer
// Assumes: one clock, synchronous active-low reset
// Notes:   in_ready is registered so the source sees a flop
`timescale 1ns/10ps
`default_nettype none
module spk_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = 4
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_ptr_q];

    always_comb begin
        cnt_d = cnt_q;
        if (push & ~pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop & ~push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            in_ready <= 1'b0;
        end else begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
            cnt_q    <= cnt_d;
            in_ready <= (cnt_d != (AW+1)'(DEPTH));
        end
    end
endmodule : spk_fifo
`default_nettype wire

// ===== src/spk_packer.sv
// Purpose: split messages into segments and pack them into seven-byte units
// Assumes: source and controller logic run on ref_clk; no resync, no pipelining
// Notes:
// Notes on behaviour
// - both compact options may be enabled together
// - packing fills spare bytes with next segment
// - packing sets next-position flag on payload segments
// - without long segments every unit starts controlled
// - default segment payload at most width minus one
// - long segments up to 63 bytes span units
// - long mode allows pure payload continuation units
// - long messages split into several segments
// - every segment gets its own control byte
// - idle control byte when nothing more pending
// - length low bits, flags weigh 64, 128
// - message end flag only on last segment
// - mode bit0 packing, bit1 long, reset zero
// - default mode leaves spare bytes, new unit
// - sequence counter increments after each unit
`timescale 1ns/10ps
`default_nettype none
module spk_packer
    import spk_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    input  wire logic [7:0]   in_data,
    input  wire logic         in_last,
    output var  logic         in_ready,
    input  wire logic [7:0]   compact_arrangement_mode_register,
    input  wire logic [7:0]   sequence_acknowledge,
    output var  logic [55:0]  unit_data,
    output var  logic         unit_strobe,
    output var  logic [7:0]   upstream_sequence_counter
);
    import spk_pkg::*;

    spk_state_e                st_q;
    spk_state_e                st_d;
    logic [BUS_CNT_W-1:0]      bus_cnt_q;
    logic                      tick_q;
    logic [7:0]                mode_q;
    logic [7:0]                unit_q [0:UNIT_BYTES-1];
    logic [7:0]                seg_buf [0:SEG_BUF_DEPTH-1];
    logic [POS_W-1:0]          pos_q;
    logic [SEG_LEN_W-1:0]      gcnt_q;
    logic [SEG_LEN_W-1:0]      rd_q;
    logic [SEG_LEN_W-1:0]      seg_len_q;
    logic                      seg_end_q;
    logic                      cont_q;
    logic                      mid_msg_q;
    logic                      idle_sent_q;
    logic [55:0]               unit_flat;

    wire                       pop;
    wire                       fifo_valid;
    wire [FIFO_WIDTH-1:0]      fifo_word;
    wire [7:0]                 fifo_data = fifo_word[7:0];
    wire                       fifo_last = fifo_word[8];

    spk_fifo #(
        .WIDTH     (FIFO_WIDTH),
        .DEPTH     (FIFO_DEPTH),
        .AW        (FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .in_valid  (in_valid),
        .in_data   ({in_last, in_data}),
        .in_ready  (in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_word),
        .out_ready (pop)
    );

    // mode changes take effect only at a fresh unit outside a message
    wire pack_q = mode_q[MODE_PACK_BIT];
    wire long_q = mode_q[MODE_LONG_BIT];

    wire in_wait    = (st_q == ST_WAIT);
    wire in_gather  = (st_q == ST_GATHER);
    wire in_ctrl    = (st_q == ST_CTRL);
    wire in_data_st = (st_q == ST_DATA);
    wire in_send    = (st_q == ST_SEND);

    // no new unit before the previous one is acknowledged by the controller
    wire acked  = (sequence_acknowledge == upstream_sequence_counter);
    wire work   = cont_q | fifo_valid | (~idle_sent_q & ~mid_msg_q);
    wire start  = in_wait & tick_q & acked & work;
    wire remode = start & ~cont_q & ~mid_msg_q;

    // segment length limit follows the room left in the unit unless long
    wire [SEG_LEN_W-1:0] room_lim = SEG_LEN_W'(UNIT_BYTES - 1) - SEG_LEN_W'(pos_q);
    wire [SEG_LEN_W-1:0] seg_lim  = long_q ? SEG_LEN_W'(SEG_MAX_LONG)
                                           : room_lim;
    wire at_seg_start = (gcnt_q == '0);
    wire no_room  = in_gather & at_seg_start & ~long_q
                    & (pos_q >= POS_W'(UNIT_BYTES - 1));
    wire go_idle  = in_gather & at_seg_start & ~fifo_valid & ~mid_msg_q & ~no_room;
    wire idle_wr  = go_idle & ~((pos_q == '0) & idle_sent_q);
    assign pop    = in_gather & fifo_valid & ~no_room;
    wire [SEG_LEN_W-1:0] gcnt_inc = gcnt_q + 1'b1;
    // a message longer than the limit is cut into further segments
    wire seg_close = pop & (fifo_last | (gcnt_inc == seg_lim));

    // control byte: length, next-position flag, end flag
    wire [7:0] cb;
    assign cb[SEG_LEN_W-1:0]   = seg_len_q;
    assign cb[CB_NEXT_POS_BIT] = pack_q;
    assign cb[CB_END_BIT]      = seg_end_q;

    wire       wr_en   = in_ctrl | in_data_st | idle_wr;
    wire [7:0] wr_byte = in_ctrl ? cb
                       : in_data_st ? seg_buf[rd_q]
                       : IDLE_CB;
    wire unit_full    = (pos_q == POS_W'(UNIT_BYTES - 1));
    wire seg_last_b   = in_data_st & ((rd_q + 1'b1) == seg_len_q);
    // default mode: spare bytes after a message end stay unused
    wire close_after  = unit_full | (seg_end_q & ~pack_q);
    wire ctrl_spills  = in_ctrl & unit_full;
    wire data_spills  = in_data_st & unit_full & ~seg_last_b;

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_WAIT: begin
                if (start) begin
                    st_d = cont_q ? ST_DATA : ST_GATHER;
                end
            end
            ST_GATHER: begin
                if (no_room | idle_wr) begin
                    st_d = ST_SEND;
                end else if (go_idle) begin
                    st_d = ST_WAIT;
                end else if (seg_close) begin
                    st_d = ST_CTRL;
                end
            end
            ST_CTRL: begin
                st_d = unit_full ? ST_SEND : ST_DATA;
            end
            ST_DATA: begin
                if (seg_last_b) begin
                    st_d = close_after ? ST_SEND : ST_GATHER;
                end else if (unit_full) begin
                    st_d = ST_SEND;
                end
            end
            ST_SEND: begin
                st_d = ST_WAIT;
            end
            default: begin
                st_d = ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_q <= ST_WAIT;
        end else begin
            st_q <= st_d;
        end
    end

    // bus cycle enable from the reference clock
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else begin
            tick_q    <= (bus_cnt_q == BUS_CNT_W'(BUS_TICK_CYC - 1));
            bus_cnt_q <= (bus_cnt_q == BUS_CNT_W'(BUS_TICK_CYC - 1)) ? '0
                                                                      : bus_cnt_q + 1'b1;
        end
    end

    // reserved mode bits are kept but never steer anything
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
        end else if (remode) begin
            mode_q <= compact_arrangement_mode_register;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < UNIT_BYTES; gi++) begin : g_unit
            wire hit = wr_en & (pos_q == POS_W'(gi));
            always_ff @(posedge ref_clk) begin
                if (!rst_n || start) begin
                    unit_q[gi] <= 8'h00;
                end else if (hit) begin
                    unit_q[gi] <= wr_byte;
                end
            end
            assign unit_flat[gi*8 +: 8] = unit_q[gi];
        end
    endgenerate

    // segment staging: a whole segment is held before its control byte goes out
    always_ff @(posedge ref_clk) begin
        if (pop) begin
            seg_buf[gcnt_q] <= fifo_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gcnt_q    <= '0;
            seg_len_q <= '0;
            seg_end_q <= 1'b0;
            mid_msg_q <= 1'b0;
        end else if (seg_close) begin
            gcnt_q    <= '0;
            seg_len_q <= gcnt_inc;
            seg_end_q <= fifo_last;
            mid_msg_q <= ~fifo_last;
        end else if (pop) begin
            gcnt_q    <= gcnt_inc;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || start) begin
            pos_q <= '0;
        end else if (wr_en) begin
            pos_q <= pos_q + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || in_ctrl) begin
            rd_q <= '0;
        end else if (in_data_st) begin
            rd_q <= rd_q + 1'b1;
        end
    end

    // remaining payload carries into the next unit without a control byte
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cont_q <= 1'b0;
        end else if (ctrl_spills | data_spills) begin
            cont_q <= 1'b1;
        end else if (start) begin
            cont_q <= 1'b0;
        end
    end

    // one idle unit is sent when the stream runs dry, not one per bus cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            idle_sent_q <= 1'b0;
        end else if (seg_close) begin
            idle_sent_q <= 1'b0;
        end else if (idle_wr) begin
            idle_sent_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            unit_data                 <= '0;
            unit_strobe               <= 1'b0;
            upstream_sequence_counter <= SEQ_RESET;
        end else begin
            unit_strobe <= in_send;
            if (in_send) begin
                unit_data                 <= unit_flat;
                upstream_sequence_counter <= upstream_sequence_counter + 1'b1;
            end
        end
    end
endmodule : spk_packer
`default_nettype wire

// ===== tb/spk_props.sv
// Purpose: port-level properties of the packer
// Assumes: mode only changes while no unit is being built
// Notes:   bound to spk_packer after the module
`timescale 1ns/10ps
`default_nettype none
module spk_props
    import spk_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        in_valid,
    input wire logic [7:0]  in_data,
    input wire logic        in_last,
    input wire logic        in_ready,
    input wire logic [7:0]  compact_arrangement_mode_register,
    input wire logic [7:0]  sequence_acknowledge,
    input wire logic [55:0] unit_data,
    input wire logic        unit_strobe,
    input wire logic [7:0]  upstream_sequence_counter
);
    wire logic [1:0] opt = compact_arrangement_mode_register[1:0];
    wire logic [5:0] len = unit_data[5:0];
    logic [11:0]     gap_q;
    logic [11:0]     gap_d;
    logic            seen_q;
    // saturate so a long dry spell never wraps into a false short gap
    assign gap_d = unit_strobe ? 12'h000 : ((gap_q == 12'hFFF) ? gap_q : gap_q + 12'h001);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gap_q  <= 12'h000;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= gap_d;
            seen_q <= seen_q | unit_strobe;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    strobe_pulse_a: assert property (unit_strobe |=> !unit_strobe)
        else $error("unit strobe longer than one cycle");
    count_step_a: assert property (unit_strobe |->
        upstream_sequence_counter == $past(upstream_sequence_counter) + 8'h01)
        else $error("counter did not step with unit");
    count_hold_a: assert property (!unit_strobe |-> $stable(upstream_sequence_counter))
        else $error("counter moved without unit");
    ack_gate_a: assert property (unit_strobe |->
        $past(sequence_acknowledge) == $past(upstream_sequence_counter))
        else $error("unit sent while previous unacknowledged");
    unit_gap_a: assert property (unit_strobe && seen_q |-> gap_q >= 12'h76C)
        else $error("two units in one bus cycle");
    seg_limit_a: assert property (unit_strobe && !opt[1] |-> len <= 6'h06)
        else $error("segment longer than unit allows");
    tail_zero_a: assert property (unit_strobe && opt == 2'b00 |->
        (unit_data >> ({len, 3'b000} + 9'h008)) == 56'h0)
        else $error("spare bytes used in default arrangement");
    flag_clear_a: assert property (unit_strobe && opt == 2'b00 |-> !unit_data[6])
        else $error("next position flag set without packing");
    next_flag_a: assert property (unit_strobe && opt == 2'b01 && len != 6'h00 |-> unit_data[6])
        else $error("next position flag missing");
    reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=>
        !in_ready && !unit_strobe && upstream_sequence_counter == 8'h00)
        else $error("outputs not cleared by reset");
    cover property (unit_strobe && opt == 2'b11);
    cover property (unit_strobe && opt == 2'b01);
    cover property (in_valid && !in_ready);
endmodule : spk_props
bind spk_packer spk_props u_props (.ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
    .compact_arrangement_mode_register(compact_arrangement_mode_register),
    .sequence_acknowledge(sequence_acknowledge), .unit_data(unit_data),
    .unit_strobe(unit_strobe), .upstream_sequence_counter(upstream_sequence_counter));
`default_nettype wire

// ===== tb/spk_ctrl_model.sv
// Purpose: controller program that takes in units and acknowledges them
// Assumes: one unit in flight at a time
// Notes:   ack_delay stretches processing to stall the packer
`timescale 1ns/10ps
`default_nettype none
module spk_ctrl_model
    import spk_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [55:0] unit_data,
    input  wire logic        unit_strobe,
    input  wire logic [7:0]  upstream_sequence_counter,
    input  wire logic [15:0] ack_delay,
    output var  logic [7:0]  sequence_acknowledge
);
    logic [55:0] got_q[$];
    logic [15:0] wait_q;
    logic        pend_q;
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            sequence_acknowledge <= SEQ_RESET;
            wait_q <= 16'h0000;
            pend_q <= 1'b0;
        end else if (unit_strobe) begin
            // every unit is kept whole, with or without a control byte
            got_q.push_back(unit_data);
            pend_q <= 1'b1;
            wait_q <= ack_delay;
        end else if (pend_q && wait_q == 16'h0000) begin
            // ack only once the ack_delay countdown for the unit has run out
            sequence_acknowledge <= upstream_sequence_counter;
            pend_q <= 1'b0;
        end else if (pend_q) begin
            wait_q <= wait_q - 16'h0001;
        end
    end
endmodule : spk_ctrl_model
`default_nettype wire

// ===== tb/spk_packer_tb_top.sv
// Purpose: self-checking bench for the segment packer
// Assumes: mode changes only while the channel is quiet
// Notes:   one task per scenario
`timescale 1ns/10ps
`default_nettype none
module spk_packer_tb_top;
    import spk_pkg::*;
    logic        ref_clk;
    logic        rst_n;
    logic        in_valid;
    logic [7:0]  in_data;
    logic        in_last;
    logic        in_ready;
    logic [7:0]  mode;
    logic [7:0]  seq_ack;
    logic [55:0] unit_data;
    logic        unit_strobe;
    logic [7:0]  seq_cnt;
    logic [15:0] ack_delay;
    logic        full_seen;
    int          miscompares;
    int          total_checks;
    spk_packer dut (.ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
        .in_last(in_last), .in_ready(in_ready), .compact_arrangement_mode_register(mode),
        .sequence_acknowledge(seq_ack), .unit_data(unit_data), .unit_strobe(unit_strobe),
        .upstream_sequence_counter(seq_cnt));
    spk_ctrl_model ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .unit_data(unit_data),
        .unit_strobe(unit_strobe), .upstream_sequence_counter(seq_cnt),
        .ack_delay(ack_delay), .sequence_acknowledge(seq_ack));
    task automatic check(input logic [55:0] seen, input logic [55:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic push_msg(input int len, input logic [7:0] base);
        int g;
        for (int i = 0; i < len; i++) begin
            @(negedge ref_clk);
            in_valid = 1'b1;
            in_data  = base + 8'(i);
            in_last  = (i == len - 1);
            g = 0;
            while (!in_ready && g < 5000) begin
                full_seen = 1'b1;
                @(negedge ref_clk);
                g++;
            end
        end
        @(negedge ref_clk);
        in_valid = 1'b0;
        in_last  = 1'b0;
    endtask : push_msg
    task automatic get_units(input int n, output int cyc);
        cyc = 0;
        while (ctrl.got_q.size() < n && cyc < 30000) begin
            @(posedge ref_clk);
            cyc++;
        end
        check(ctrl.got_q.size() >= n, 1'b1);
    endtask : get_units
    task automatic drain(input logic [7:0] next_mode);
        repeat (3 * BUS_TICK_CYC) @(negedge ref_clk);
        ctrl.got_q.delete();
        mode = next_mode;
    endtask : drain
    task automatic run_default();
        int c;
        push_msg(2, 8'h10);
        push_msg(7, 8'h20);
        get_units(4, c);
        check(ctrl.got_q[0], 56'h00000000111082);
        check(ctrl.got_q[1], 56'h25242322212006);
        check(ctrl.got_q[2], 56'h00000000002681);
        check(ctrl.got_q[3], 56'h00000000000000);
        drain(8'h01);
    endtask : run_default
    task automatic run_pack();
        int c;
        push_msg(7, 8'h30);
        push_msg(2, 8'h40);
        get_units(2, c);
        check(ctrl.got_q[0], 56'h35343332313046);
        check(ctrl.got_q[1], 56'h00004140C236C1);
        drain(8'h02);
    endtask : run_pack
    task automatic run_long();
        int c;
        int p;
        push_msg(64, 8'h00);
        get_units(10, c);
        check(full_seen, 1'b1);
        for (int k = 0; k < 9; k++) begin
            for (int j = 0; j < 7; j++) begin
                p = k * 7 + j;
                check(ctrl.got_q[k][8*j+:8], (p == 0) ? 8'h3F : 8'(p - 1));
            end
        end
        check(ctrl.got_q[9][7:0], 8'h3E);
        drain(8'h03);
    endtask : run_long
    task automatic run_both();
        int c;
        ack_delay = 16'h0898;
        push_msg(9, 8'h50);
        push_msg(2, 8'h60);
        get_units(1, c);
        get_units(2, c);
        check(c > BUS_TICK_CYC, 1'b1);
        check(ctrl.got_q[0], 56'h555453525150C9);
        check(ctrl.got_q[1][47:0], 48'h6160C2585756);
    endtask : run_both
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        #4500000;
        miscompares++;
        close_out();
    end
    initial begin
        rst_n        = 1'b0;
        in_valid     = 1'b0;
        in_data      = 8'h00;
        in_last      = 1'b0;
        mode         = 8'hFC; // reserved bits set, both options off
        ack_delay    = 16'h0001;
        full_seen    = 1'b0;
        miscompares  = 0;
        total_checks = 0;
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        run_default();
        run_pack();
        run_long();
        run_both();
        close_out();
    end
endmodule : spk_packer_tb_top
`default_nettype wire
